/* File: verilog/lto_map.svh */
// Register offsets, field positions, reset values and sizes of the oversight.
//
// Contract
// - Three 27-bit backplane links serve base logic only.
// - Two 33-bit front links reach both processing devices.
// - Line direction set purely by control signals.
// - Front line ownership chosen per connector.
// - Transceiver enables inactive until controller configured.
// - Translator output enables deasserted until controller configured.
// - Apply transceiver requests, refuse two drivers per line.
// - Apply translator requests, never two drivers per line.
// - Failsafe and master enable come from jumpers.
// - Release control only after devices confirmed running.
`ifndef LTO_MAP_SVH
`define LTO_MAP_SVH

// ****************************************************************
// Link layout.
// ****************************************************************
`define LTO_BP_LINKS       3
`define LTO_FP_LINKS       2
`define LTO_LINKS          5
`define LTO_BP_BITS        27
`define LTO_FP_BITS        33
`define LTO_JMP_GROUPS     2

// ****************************************************************
// Register offsets (byte addresses).
// ****************************************************************
`define LTO_ADDR_CTRL      8'h00
`define LTO_ADDR_OWNER     8'h04
`define LTO_ADDR_STATUS    8'h08
`define LTO_ADDR_CONFLICT  8'h0C
`define LTO_ADDR_LINKS     8'h10

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define LTO_CTRL_RELEASE   0
`define LTO_CTRL_TP_FITTED 1
`define LTO_CTRL_RESET     2'b00
`define LTO_OWNER_RESET    2'b00
`define LTO_ST_CFG         0
`define LTO_ST_BF_OK       1
`define LTO_ST_TP_OK       2
`define LTO_ST_REL_BF      3
`define LTO_ST_REL_TP      4
`define LTO_ST_LIVE_CONF   8
`define LTO_LK_DRV         0
`define LTO_LK_RCV         8
`define LTO_LK_DIR         16

`endif

/* File: verilog/lto_pkg.sv */
// Types shared by the transceiver oversight design.
package lto_pkg;
   typedef logic [7:0]  lto_addr_t;
   typedef logic [31:0] lto_word_t;
   typedef logic [4:0]  lto_link_vec_t;
endpackage : lto_pkg

/* File: verilog/lto_sync.sv */
// Two-flop synchroniser for a vector of independent levels.
`timescale 1ns/1ps
`default_nettype none
module lto_sync #(
   parameter int W = 1
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] d_async,
   output logic      [W-1:0] q_sync
);
   logic [W-1:0] meta_r;

   // The first stage is read by the second stage only.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '0;
         q_sync <= '0;
      end else begin
         meta_r <= d_async;
         q_sync <= meta_r;
      end
   end
endmodule : lto_sync
`default_nettype wire

/* File: verilog/lto_top.sv */
// Transceiver and level translator oversight with its APB register file.
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "lto_map.svh"
module lto_top
   import lto_pkg::*;
(
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [7:0]                 paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire logic                       bsc_config_done,
   input  wire logic                       bf_running,
   input  wire logic                       tp_running,
   input  wire logic [`LTO_BP_LINKS-1:0]   bf_bp_tx,
   input  wire logic [`LTO_BP_LINKS-1:0]   bf_bp_en,
   input  wire logic [`LTO_FP_LINKS-1:0]   bf_fp_tx,
   input  wire logic [`LTO_FP_LINKS-1:0]   bf_fp_en,
   input  wire logic [`LTO_FP_LINKS-1:0]   tp_fp_tx,
   input  wire logic [`LTO_FP_LINKS-1:0]   tp_fp_en,
   input  wire logic [`LTO_JMP_GROUPS-1:0] jmp_failsafe,
   input  wire logic [`LTO_JMP_GROUPS-1:0] jmp_master_enable,
   output logic [`LTO_LINKS-1:0]           line_driver_enable,
   output logic [`LTO_LINKS-1:0]           line_receiver_enable_n,
   output logic [`LTO_LINKS-1:0]           xlat_dir,
   output logic [`LTO_LINKS-1:0]           xlat_bf_oe_n,
   output logic [`LTO_FP_LINKS-1:0]        xlat_tp_oe_n,
   output logic [`LTO_JMP_GROUPS-1:0]      lvds_failsafe,
   output logic [`LTO_JMP_GROUPS-1:0]      lvds_master_enable
);

   // ****************************************************************
   // Pin synchronisation.
   // ****************************************************************
   // Every request pin is asynchronous to pclk, so the whole bundle passes
   // one two-stage synchroniser; the bits settle independently.
   localparam int SW = 21;
   logic [SW-1:0] sync_q;
   logic [`LTO_BP_LINKS-1:0] s_bp_tx;
   logic [`LTO_BP_LINKS-1:0] s_bp_en;
   logic [`LTO_FP_LINKS-1:0] s_bf_tx;
   logic [`LTO_FP_LINKS-1:0] s_bf_en;
   logic [`LTO_FP_LINKS-1:0] s_tp_tx;
   logic [`LTO_FP_LINKS-1:0] s_tp_en;
   logic s_cfg;
   logic s_bf_ok;
   logic s_tp_ok;
   logic [`LTO_JMP_GROUPS-1:0] s_fs;
   logic [`LTO_JMP_GROUPS-1:0] s_me;

   lto_sync #(.W(SW)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d_async ({jmp_master_enable, jmp_failsafe, tp_running, bf_running,
                 bsc_config_done, tp_fp_en, tp_fp_tx, bf_fp_en, bf_fp_tx,
                 bf_bp_en, bf_bp_tx}),
      .q_sync  (sync_q)
   );

   assign {s_me, s_fs, s_tp_ok, s_bf_ok, s_cfg, s_tp_en, s_tp_tx,
           s_bf_en, s_bf_tx, s_bp_en, s_bp_tx} = sync_q;

   // Jumpers go straight to the transceivers, untouched by arbitration.
   assign lvds_failsafe      = s_fs;
   assign lvds_master_enable = s_me;

   // ****************************************************************
   // Register file.
   // ****************************************************************
   logic [1:0]               ctrl_r;
   logic [`LTO_FP_LINKS-1:0] owner_r;
   logic [`LTO_FP_LINKS-1:0] conflict_r;
   logic [`LTO_FP_LINKS-1:0] conflict_nxt;

   // Writes land on the access edge; only the low two bits of CTRL, OWNER
   // and CONFLICT are stored, the rest read back as zero.
   wire acc      = psel & penable;
   wire wr       = acc & pwrite;
   wire hit_ctl  = (paddr == `LTO_ADDR_CTRL);
   wire hit_own  = (paddr == `LTO_ADDR_OWNER);
   wire hit_st   = (paddr == `LTO_ADDR_STATUS);
   wire hit_cf   = (paddr == `LTO_ADDR_CONFLICT);
   wire hit_lk   = (paddr == `LTO_ADDR_LINKS);
   wire mapped   = hit_ctl | hit_own | hit_st | hit_cf | hit_lk;
   wire cf_clear = wr & hit_cf;

   // ****************************************************************
   // Release and arbitration.
   // ****************************************************************
   // Nothing is released before the controller itself is configured,
   // software has confirmed, and the owning device reports running.
   wire rel_bf = s_cfg & ctrl_r[`LTO_CTRL_RELEASE] & s_bf_ok;
   wire rel_tp = s_cfg & ctrl_r[`LTO_CTRL_RELEASE]
               & ctrl_r[`LTO_CTRL_TP_FITTED] & s_tp_ok;

   // Both devices asking to drive one connector is refused outright.
   // Ownership is ignored here, since the other device would fight anyway.
   wire [`LTO_FP_LINKS-1:0] live_conf =
      s_bf_en & s_bf_tx & s_tp_en & s_tp_tx;

   // Per-link request after ownership: backplane links always base logic.
   wire [`LTO_LINKS-1:0] want_en;
   wire [`LTO_LINKS-1:0] want_tx;
   wire [`LTO_LINKS-1:0] want_own;
   wire [`LTO_LINKS-1:0] allow;

   assign want_en[2:0]  = s_bp_en;
   assign want_tx[2:0]  = s_bp_tx;
   assign want_own[2:0] = 3'b000;
   assign allow[2:0]    = {3{rel_bf}};
   assign want_own[4:3] = owner_r;
   assign want_en[4:3]  = (owner_r & s_tp_en)
                        | (~owner_r & s_bf_en);
   assign want_tx[4:3]  = (owner_r & s_tp_tx)
                        | (~owner_r & s_bf_tx);
   assign allow[4:3]    = ((owner_r & {2{rel_tp}}) | (~owner_r & {2{rel_bf}}))
                        & ~live_conf;

   // ****************************************************************
   // Per-link output control.
   // ****************************************************************
   logic [`LTO_LINKS-1:0] dir_r;
   logic [`LTO_LINKS-1:0] own_r;
   logic [`LTO_LINKS-1:0] drv_r;
   logic [`LTO_LINKS-1:0] rcv_n_r;
   logic [`LTO_LINKS-1:0] oe_n_r;

   genvar i;
   generate
      for (i = 0; i < `LTO_LINKS; i++) begin : g_link
         // A change of direction or owner first turns the link off, then
         // moves the direction while idle, then re-enables: break before
         // make, so no edge ever sees two drivers on either side.
         wire changed = (want_tx[i] != dir_r[i]) | (want_own[i] != own_r[i]);
         wire go      = allow[i] & want_en[i] & ~changed;
         wire move    = oe_n_r[i] & ~drv_r[i] & rcv_n_r[i];

         // Flops reset to every enable off; only release lifts them.
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               dir_r[i]   <= 1'b0;
               own_r[i]   <= 1'b0;
               drv_r[i]   <= 1'b0;
               rcv_n_r[i] <= 1'b1;
               oe_n_r[i]  <= 1'b1;
            end else begin
               if (move) begin
                  dir_r[i] <= want_tx[i];
                  own_r[i] <= want_own[i];
               end
               drv_r[i]   <= go & want_tx[i];
               rcv_n_r[i] <= ~(go & ~want_tx[i]);
               oe_n_r[i]  <= ~go;
            end
         end
      end
   endgenerate

   // The enables leave flops, so a glitch on a request pin or on the
   // decode never reaches a transceiver.
   assign line_driver_enable     = drv_r;
   assign line_receiver_enable_n = rcv_n_r;
   assign xlat_dir               = dir_r;
   // Only the owning device's translator may be opened.
   assign xlat_bf_oe_n = oe_n_r | {own_r[4:3], 3'b000};
   assign xlat_tp_oe_n = oe_n_r[4:3] | ~own_r[4:3];

   // ****************************************************************
   // Register writes and the sticky conflict flags.
   // ****************************************************************
   // A conflict seen in the clearing cycle stays set.
   assign conflict_nxt = (conflict_r & ~(cf_clear ? pwdata[1:0] : 2'b00))
                       | live_conf;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r     <= `LTO_CTRL_RESET;
         owner_r    <= `LTO_OWNER_RESET;
         conflict_r <= 2'b00;
      end else begin
         if (wr && hit_ctl) begin
            ctrl_r <= pwdata[1:0];
         end
         if (wr && hit_own) begin
            owner_r <= pwdata[1:0];
         end
         conflict_r <= conflict_nxt;
      end
   end

   // ****************************************************************
   // Read path.
   // ****************************************************************
   wire [31:0] st_word = {22'h00_0000, live_conf, 3'b000, rel_tp, rel_bf,
                          s_tp_ok, s_bf_ok, s_cfg};
   wire [31:0] lk_word = {11'h000, dir_r, 3'b000, ~rcv_n_r, 3'b000, drv_r};
   wire [31:0] rd_mux  = hit_ctl ? {30'h0000_0000, ctrl_r}  :
                         hit_own ? {30'h0000_0000, owner_r} :
                         hit_st  ? st_word                  :
                         hit_cf  ? {30'h0000_0000, conflict_r} :
                         hit_lk  ? lk_word                  : 32'h0000_0000;

   // Read data is captured in the setup cycle, so a status read shows the
   // levels one edge before the access edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_mux;
      end
   end

   // Zero wait states; unmapped addresses answer with an error.
   assign pready  = 1'b1;
   assign pslverr = acc & ~mapped;

endmodule : lto_top
`default_nettype wire

/* File: tb/lto_top_props.sv */
// Concurrent checks on the oversight ports.
`timescale 1ns/1ps
`default_nettype none
module lto_top_props (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       bsc_config_done,
   input wire logic       bf_running,
   input wire logic [2:0] bf_bp_tx,
   input wire logic [2:0] bf_bp_en,
   input wire logic [1:0] bf_fp_tx,
   input wire logic [1:0] bf_fp_en,
   input wire logic [1:0] tp_fp_tx,
   input wire logic [1:0] tp_fp_en,
   input wire logic [1:0] jmp_failsafe,
   input wire logic [1:0] jmp_master_enable,
   input wire logic [4:0] line_driver_enable,
   input wire logic [4:0] line_receiver_enable_n,
   input wire logic [4:0] xlat_bf_oe_n,
   input wire logic [1:0] xlat_tp_oe_n,
   input wire logic [1:0] lvds_failsafe,
   input wire logic [1:0] lvds_master_enable
);
   // Pins pass a sync and a register, so the waits below allow five edges.
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic [1:0] clash = bf_fp_tx & bf_fp_en & tp_fp_tx & tp_fp_en;
   wire logic [3:0] jmp = {jmp_failsafe, jmp_master_enable};
   wire logic [3:0] lvds = {lvds_failsafe, lvds_master_enable};
   wire logic want0 = bf_fp_tx[0] & bf_fp_en[0] | tp_fp_tx[0] & tp_fp_en[0];
   wire logic tx0 = bf_bp_tx[0] & bf_bp_en[0];
   wire logic rx1 = !bf_bp_tx[1] & bf_bp_en[1];
   wire logic off_all = !line_driver_enable && &{line_receiver_enable_n,
      xlat_bf_oe_n, xlat_tp_oe_n};
   cfg_off_a: assert property (
      (!bsc_config_done)[*5] |-> off_all)
      else $error("enable before configuration");
   bf_rel_a: assert property (
      (!bf_running)[*5] |->
      !line_driver_enable[2:0] && &xlat_bf_oe_n[2:0])
      else $error("backplane live without base logic");
   dual_oe_a: assert property (
      !(~xlat_bf_oe_n[4:3] & ~xlat_tp_oe_n))
      else $error("two translators drive one line");
   clash0_a: assert property (
      clash[0] [*5] |-> !line_driver_enable[3])
      else $error("connector driven in conflict");
   jmp_pass_a: assert property (
      lvds == $past(jmp, 2) || lvds == $past(jmp, 3))
      else $error("jumper levels not passed through");
   bp_drv_a: assert property (
      $rose(line_driver_enable[0]) |-> $past(tx0, 3) || $past(tx0, 4))
      else $error("driver without request");
   bp_rcv_a: assert property (
      $fell(line_receiver_enable_n[1]) |-> $past(rx1, 3) || $past(rx1, 4))
      else $error("receiver without request");
   fp_drv_a: assert property (
      $rose(line_driver_enable[3]) |-> $past(want0, 3) || $past(want0, 4))
      else $error("front driver unasked");
endmodule : lto_top_props
bind lto_top lto_top_props u_props (
   .pclk                   (pclk),
   .presetn                (presetn),
   .bsc_config_done        (bsc_config_done),
   .bf_running             (bf_running),
   .bf_bp_tx               (bf_bp_tx),
   .bf_bp_en               (bf_bp_en),
   .bf_fp_tx               (bf_fp_tx),
   .bf_fp_en               (bf_fp_en),
   .tp_fp_tx               (tp_fp_tx),
   .tp_fp_en               (tp_fp_en),
   .jmp_failsafe           (jmp_failsafe),
   .jmp_master_enable      (jmp_master_enable),
   .line_driver_enable     (line_driver_enable),
   .line_receiver_enable_n (line_receiver_enable_n),
   .xlat_bf_oe_n           (xlat_bf_oe_n),
   .xlat_tp_oe_n           (xlat_tp_oe_n),
   .lvds_failsafe          (lvds_failsafe),
   .lvds_master_enable     (lvds_master_enable)
);
`default_nettype wire

/* File: tb/lto_far_end.sv */
// Behavioural model of the base and topological processing devices.
`timescale 1ns/1ps
`default_nettype none
module lto_far_end (
   input  wire logic        pclk,
   input  wire logic [1:0]  run,
   input  wire logic [13:0] want,
   output logic             bf_running,
   output logic             tp_running,
   output logic [2:0]       bf_bp_tx,
   output logic [2:0]       bf_bp_en,
   output logic [1:0]       bf_fp_tx,
   output logic [1:0]       bf_fp_en,
   output logic [1:0]       tp_fp_tx,
   output logic [1:0]       tp_fp_en
);
   // A set moves as one transmit and enable pair, never bit by bit.
   logic [15:0] pins_r = 16'h0000;
   always @(posedge pclk) pins_r <= {run, want};
   assign {tp_running, bf_running, tp_fp_en, tp_fp_tx, bf_fp_en, bf_fp_tx,
           bf_bp_en, bf_bp_tx} = pins_r;
endmodule : lto_far_end
`default_nettype wire

/* File: tb/lvds_transceiver_oversight_tb.sv */
// Self-checking bench for the transceiver oversight.
`timescale 1ns/1ps
`default_nettype none
`include "lto_map.svh"
module lvds_transceiver_oversight_tb import lto_pkg::*;;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
   logic        bsc_config_done, bf_running, tp_running;
   lto_addr_t   paddr;
   lto_word_t   pwdata, prdata, q;
   logic [2:0]  bf_bp_tx, bf_bp_en;
   logic [1:0]  bf_fp_tx, bf_fp_en, tp_fp_tx, tp_fp_en, run, xlat_tp_oe_n;
   logic [1:0]  jmp_failsafe, jmp_master_enable, lvds_failsafe;
   logic [1:0]  lvds_master_enable;
   logic [4:0]  line_driver_enable, line_receiver_enable_n, xlat_dir;
   logic [4:0]  xlat_bf_oe_n;
   logic [13:0] want;
   int          err_total = 0;
   int          n_compared = 0;
   lto_top      dut (
      .pclk                   (pclk),
      .presetn                (presetn),
      .psel                   (psel),
      .penable                (penable),
      .pwrite                 (pwrite),
      .paddr                  (paddr),
      .pwdata                 (pwdata),
      .prdata                 (prdata),
      .pready                 (pready),
      .pslverr                (pslverr),
      .bsc_config_done        (bsc_config_done),
      .bf_running             (bf_running),
      .tp_running             (tp_running),
      .bf_bp_tx               (bf_bp_tx),
      .bf_bp_en               (bf_bp_en),
      .bf_fp_tx               (bf_fp_tx),
      .bf_fp_en               (bf_fp_en),
      .tp_fp_tx               (tp_fp_tx),
      .tp_fp_en               (tp_fp_en),
      .jmp_failsafe           (jmp_failsafe),
      .jmp_master_enable      (jmp_master_enable),
      .line_driver_enable     (line_driver_enable),
      .line_receiver_enable_n (line_receiver_enable_n),
      .xlat_dir               (xlat_dir),
      .xlat_bf_oe_n           (xlat_bf_oe_n),
      .xlat_tp_oe_n           (xlat_tp_oe_n),
      .lvds_failsafe          (lvds_failsafe),
      .lvds_master_enable     (lvds_master_enable)
   );
   lto_far_end  u_far (
      .pclk       (pclk),
      .run        (run),
      .want       (want),
      .bf_running (bf_running),
      .tp_running (tp_running),
      .bf_bp_tx   (bf_bp_tx),
      .bf_bp_en   (bf_bp_en),
      .bf_fp_tx   (bf_fp_tx),
      .bf_fp_en   (bf_fp_en),
      .tp_fp_tx   (tp_fp_tx),
      .tp_fp_en   (tp_fp_en)
   );
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task chk(input lto_word_t got, input lto_word_t exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   // The idle edge at the end keeps two transfers off one time step.
   task apb(input logic wr, input lto_addr_t a, input lto_word_t d);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      slv = pslverr;
      {psel, penable} <= 2'b00;
      @(posedge pclk);
   endtask : apb
   task t_hold;
      {want, run} <= {14'h0019, 2'h3};
      apb(1'b0, `LTO_ADDR_CTRL, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      apb(1'b1, `LTO_ADDR_CTRL, 32'h0000_0001);
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk({slv, q[30:0]}, 32'h8000_0000);
      {jmp_failsafe, jmp_master_enable} <= 4'h9;
      repeat (8) @(posedge pclk);
      chk({line_driver_enable, line_receiver_enable_n,
           xlat_bf_oe_n, xlat_tp_oe_n}, 17'h0_0FFF);
      chk({lvds_failsafe, lvds_master_enable}, 4'h9);
      apb(1'b0, `LTO_ADDR_STATUS, 32'h0000_0000);
      chk(q, 32'h0000_0006);
      $display("test hold done");
   endtask : t_hold
   task t_back;
      bsc_config_done <= 1'b1;
      repeat (8) @(posedge pclk);
      chk({line_driver_enable[1:0],
           line_receiver_enable_n[1], xlat_bf_oe_n[1:0], xlat_dir[1:0],
           xlat_tp_oe_n}, 9'h087);
      apb(1'b0, `LTO_ADDR_LINKS, 32'h0000_0000);
      chk(q & 32'h0003_0203, 32'h0001_0201);
      run <= 2'h2;
      repeat (8) @(posedge pclk);
      chk({line_driver_enable, xlat_bf_oe_n}, 10'h01F);
      run <= 2'h3;
      $display("test back done");
   endtask : t_back
   task t_front;
      apb(1'b1, `LTO_ADDR_CTRL, 32'h0000_0003);
      apb(1'b1, `LTO_ADDR_OWNER, 32'h0000_0001);
      want <= 14'h1680;
      repeat (8) @(posedge pclk);
      chk({line_driver_enable[4:3], xlat_tp_oe_n,
           xlat_bf_oe_n[4:3]}, 6'h39);
      want <= 14'h17C0;
      repeat (8) @(posedge pclk);
      chk(line_driver_enable[3], 1'b0);
      apb(1'b0, `LTO_ADDR_STATUS, 32'h0000_0000);
      chk(q, 32'h0000_011F);
      want <= 14'h1680;
      repeat (8) @(posedge pclk);
      chk(line_driver_enable[3], 1'b1);
      apb(1'b0, `LTO_ADDR_CONFLICT, 32'h0000_0000);
      chk(q[1:0], 2'h1);
      apb(1'b1, `LTO_ADDR_CONFLICT, 32'h0000_0001);
      apb(1'b0, `LTO_ADDR_CONFLICT, 32'h0000_0000);
      chk(q[1:0], 2'h0);
      apb(1'b0, `LTO_ADDR_STATUS, 32'h0000_0000);
      chk(q, 32'h0000_001F);
      $display("test front done");
   endtask : t_front
   task conclude;
      $display("compared %0d, mismatched %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : conclude
   initial begin
      {psel, penable, pwrite, paddr, pwdata, bsc_config_done, slv} = '0;
      {run, want, jmp_failsafe, jmp_master_enable, presetn} = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_hold();
      t_back();
      t_front();
      conclude();
   end
   // The tests take about 90 edges; 1500 is over sixteen times that, so reaching it means a hang.
   initial begin
      repeat (1500) @(posedge pclk);
      err_total++;
      conclude();
   end
endmodule : lvds_transceiver_oversight_tb
`default_nettype wire
